// ---- verilog/isf_defs.vh ----
`ifndef ISF_DEFS_VH
`define ISF_DEFS_VH

// Register indices as printed; byte address is four times the index
`define ISF_LS_LIMIT_IDX 8'h0a
`define ISF_HS_LIMIT_IDX 8'ha4
`define ISF_CTRL_IDX 8'h00
`define ISF_STATUS_IDX 8'h01
`define ISF_LS_LIMIT_ADDR 12'h028
`define ISF_HS_LIMIT_ADDR 12'h290
`define ISF_CTRL_ADDR 12'h000
`define ISF_STATUS_ADDR 12'h004

// Field positions
`define ISF_LIMIT_MSB 7
`define ISF_CTRL_EN_BIT 0
`define ISF_CTRL_HS_BIT 1

// Reset values and the minimum limit that writes are clamped to
`define ISF_LS_LIMIT_RST 8'h05
`define ISF_HS_LIMIT_RST 8'h01
`define ISF_LIMIT_MIN 8'h01

`endif

// ---- verilog/isf_line_filter.v ----
`timescale 1ns/1ns
`include "isf_defs.vh"

module isf_line_filter #(
   parameter WIDTH = 8
) (
   input wire sys_clk,
   input wire rst,
   input wire rawLine,
   input wire [WIDTH-1:0] limit,
   output reg filtLine
);

   reg [WIDTH-1:0] runCnt_r;

   // Output flips only once the new level has lasted more than limit cycles
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         runCnt_r <= {WIDTH{1'b0}};
         filtLine <= 1'b1;
      end else if (rawLine == filtLine) begin
         runCnt_r <= {WIDTH{1'b0}};
      end else if (runCnt_r >= limit) begin
         filtLine <= rawLine;
         runCnt_r <= {WIDTH{1'b0}};
      end else begin
         runCnt_r <= runCnt_r + 1'b1;
      end
   end

endmodule

// ---- verilog/isf_spike_limits.v ----
`timescale 1ns/1ns
`include "isf_defs.vh"

module isf_spike_limits #(
   parameter LIMIT_W = 8
) (
   input wire sys_clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire sclIn,
   input wire sdaIn,
   output reg sclFilt,
   output reg sdaFilt,
   output reg ctrlEnable
);

   ////////////////////////////////////////////////////////////////////
   reg [LIMIT_W-1:0] lsLimit_r;
   reg [LIMIT_W-1:0] hsLimit_r;
   reg hsMode_r;
   wire [LIMIT_W-1:0] actLimit;
   wire [1:0] rawLines;
   wire [1:0] cleanLines;
   wire setup;
   wire access;
   wire wrLimit;
   wire [LIMIT_W-1:0] wrVal;
   reg mapped;
   reg [31:0] rdVal;

   // Clamp to the minimum so a zero write cannot disable filtering
   function [LIMIT_W-1:0] clampMin;
      input [LIMIT_W-1:0] v;
      begin
         clampMin = (v < `ISF_LIMIT_MIN) ? `ISF_LIMIT_MIN : v;
      end
   endfunction

   assign setup = psel & ~penable;
   // The completing edge of a transfer is the only one at which a write may land
   assign access = psel & penable & pready;
   assign wrVal = clampMin(pwdata[LIMIT_W-1:0]);
   assign wrLimit = access & pwrite & ~ctrlEnable;
   assign rawLines = {sdaIn, sclIn};
   assign actLimit = hsMode_r ? hsLimit_r : lsLimit_r;

   ////////////////////////////////////////////////////////////////////
   always @* begin
      mapped = 1'b1;
      rdVal = 32'h00000000;
      case (paddr)
         `ISF_CTRL_ADDR: begin
            rdVal[`ISF_CTRL_EN_BIT] = ctrlEnable;
            rdVal[`ISF_CTRL_HS_BIT] = hsMode_r;
         end
         `ISF_STATUS_ADDR: begin
            rdVal[1:0] = {sdaFilt, sclFilt};
         end
         `ISF_LS_LIMIT_ADDR: rdVal[LIMIT_W-1:0] = lsLimit_r;
         `ISF_HS_LIMIT_ADDR: rdVal[LIMIT_W-1:0] = hsLimit_r;
         default: mapped = 1'b0;
      endcase
   end

   // Answer in the first access cycle; writes land only at the completing edge
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lsLimit_r <= `ISF_LS_LIMIT_RST;
         hsLimit_r <= `ISF_HS_LIMIT_RST;
         hsMode_r <= 1'b0;
         ctrlEnable <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         prdata <= (setup & ~pwrite) ? rdVal : 32'h00000000;
         if (access & pwrite & (paddr == `ISF_CTRL_ADDR)) begin
            ctrlEnable <= pwdata[`ISF_CTRL_EN_BIT];
            hsMode_r <= pwdata[`ISF_CTRL_HS_BIT];
         end
         if (wrLimit & (paddr == `ISF_LS_LIMIT_ADDR))
            lsLimit_r <= wrVal;
         if (wrLimit & (paddr == `ISF_HS_LIMIT_ADDR))
            hsLimit_r <= wrVal;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Both lines share the active limit, so a mode switch retunes them together
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_line
         isf_line_filter #(.WIDTH(LIMIT_W)) u_filt (
            .sys_clk(sys_clk),
            .rst(rst),
            .rawLine(rawLines[gi]),
            .limit(actLimit),
            .filtLine(cleanLines[gi])
         );
      end
   endgenerate

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sclFilt <= 1'b1;
         sdaFilt <= 1'b1;
      end else begin
         sclFilt <= cleanLines[0];
         sdaFilt <= cleanLines[1];
      end
   end

endmodule

// ---- bench/isf_spike_limits_assertions.sv ----
`timescale 1ns/1ns
module isf_chk(input wire sys_clk, rst, psel, penable, pwrite, pready, sclIn, sclFilt,
   input wire pslverr, sdaIn, sdaFilt,
   input wire ctrlEnable, input wire [11:0] paddr, input wire [31:0] pwdata, prdata);
default clocking @(posedge sys_clk); endclocking
default disable iff (rst);
wire su = psel && !penable, lim = paddr == 12'h028 || paddr == 12'h290;
wire acc = psel && penable && pready;
AST_RDY: assert property (su |=> pready) else $error("late");
AST_ONE: assert property (pready |=> !pready) else $error("long");
AST_LIM: assert property (pready && !pwrite && lim |->
   prdata inside {[1:255]}) else $error("lim");
AST_SCL: assert property ($changed(sclFilt) |->
   $past(sclIn, 2) == sclFilt && $past(sclIn, 3) == sclFilt) else $error("scl");
AST_SDA: assert property ($changed(sdaFilt) |->
   $past(sdaIn, 2) == sdaFilt && $past(sdaIn, 3) == sdaFilt) else $error("sda");
AST_EN: assert property (acc && pwrite && paddr == 12'h000 |=>
   ctrlEnable == $past(pwdata[0])) else $error("en");
AST_ERR: assert property (pready && lim |-> !pslverr) else $error("err");
cover property (su && lim && ctrlEnable);
cover property ($fell(sclFilt));
cover property (pready && lim);
endmodule
bind isf_spike_limits isf_chk asrt(.*);

// ---- bench/isf_line_src.sv ----
`timescale 1ns/1ns
module isf_line_src(input wire sys_clk, output logic line = 1'b1);
// Pull-up: idles high
task pulse(input integer n);
   @(posedge sys_clk);
   line <= 1'b0;
   repeat (n) @(posedge sys_clk);
   line <= 1'b1;
endtask
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ns
module testbench;
logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
logic [11:0] paddr = 0;
logic [31:0] pwdata = 0;
wire [31:0] prdata;
wire pready, pslverr, sclIn, sdaIn, sclFilt, sdaFilt, ctrlEnable;
integer miscompares = 0, cmp_count = 0;
isf_spike_limits dut(.*);
isf_line_src src(.sys_clk, .line(sclIn));
isf_line_src sdaSrc(.sys_clk, .line(sdaIn));
initial forever #5 sys_clk = ~sys_clk;
initial #20000 begin
   miscompares++;
   summarize;
end
task chk(input [31:0] g, e);
   cmp_count++;
   miscompares += g !== e;
   if (g !== e) $display("unexpected %0t %h %h", $time, g, e);
endtask
task apb(input w, input [11:0] a, input [31:0] d);
   @(posedge sys_clk);
   psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
   @(posedge sys_clk) penable <= 1;
   do @(posedge sys_clk); while (pready !== 1'b1);
   psel <= 0; penable <= 0;
   if (!w) chk(prdata | {pslverr, 31'h0}, d);
endtask
task summarize;
   $display("%0d bad of %0d", miscompares, cmp_count);
   if (!miscompares && cmp_count) $display("Test passed");
   else $display("Test failed");
   $finish;
endtask
initial begin
   repeat (10) @(posedge sys_clk);
   rst <= 0;
   apb(0,12'h028,5);
   apb(0,12'h290,1);
   apb(1,12'h028,0);
   apb(0,12'h028,1);
   apb(1,12'h028,32'hffffff03);
   apb(1,12'h290,2);
   apb(0,12'h290,2);
   src.pulse(3);
   repeat (2) @(negedge sys_clk);
   chk(sclFilt, 1);
   sdaSrc.pulse(4);
   @(negedge sys_clk);
   chk(sdaFilt, 1);
   @(negedge sys_clk);
   chk(sdaFilt, 0);
   apb(0,12'h004,1);
   apb(1,12'h000,3);
   apb(0,12'h000,3);
   chk(ctrlEnable, 1);
   chk(sdaFilt, 1);
   apb(1,12'h290,1);
   apb(1,12'h028,7);
   apb(0,12'h290,2);
   apb(0,12'h028,3);
   src.pulse(2);
   repeat (2) @(negedge sys_clk);
   chk(sclFilt, 1);
   src.pulse(3);
   @(negedge sys_clk);
   chk(sclFilt, 1);
   @(negedge sys_clk);
   chk(sclFilt, 0);
   apb(0,12'h100,32'h80000000);
   summarize;
end
endmodule
